// >>> rtl/rhpm_defs.vh
// Constants for the radio host pin mux: APB register map, fields, resets.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef RHPM_DEFS_VH
`define RHPM_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RHPM_ADDR_ROUTE 12'h000
`define RHPM_ADDR_AUDIO 12'h004
`define RHPM_ADDR_GPIO 12'h008
`define RHPM_ADDR_PWR 12'h00C
`define RHPM_ADDR_STATUS 12'h010

// ****************************************************************
// Field positions
// ****************************************************************
`define RHPM_ROUTE_PCM_BIT 0
`define RHPM_AUDIO_MASTER_BIT 0
`define RHPM_GPIO0_WAKE_BIT 0
`define RHPM_GPIO0_OE_BIT 1
`define RHPM_GPIO0_DO_BIT 2
`define RHPM_WAKE_OE_BIT 3
`define RHPM_WAKE_DO_BIT 4
`define RHPM_PWR_WL_PD_BIT 0
`define RHPM_PWR_RD_PD_BIT 1

// ****************************************************************
// Reset values
// ****************************************************************
`define RHPM_ROUTE_RST 32'h0000_0000
`define RHPM_AUDIO_RST 32'h0000_0000
`define RHPM_GPIO_RST 32'h0000_0000
`define RHPM_PWR_RST 32'h0000_0003

`endif

// >>> rtl/rhpm_pin_mux.v
// Radio host pin mux: routes host serial link, wake lines, audio pins and
// power-on inputs. Assumes an APB master on sys_clk_in and pin-level
// three-signal ports resolved by the bench.
`timescale 1ns/1ps
`include "rhpm_defs.vh"

// Function
// - After reset the wake pins are wake/GPIO and the four link pins serial.
// - PCM routing puts clock on RTS, out on CTS, sync on host-wake, in on dev-wake.
// - With PCM routed, sleep signaling goes in-band over the two data lines.
// - Clear-to-send is active low and transmission holds while it is high.
// - Request-to-send is driven low to let the host send.
// - Serial in receives and serial out transmits, one direction each.
// - WLAN power-on low holds WLAN in reset with regulators off.
// - Radio power-on low holds the radio section in reset, regulators off.
// - Audio clock and word select are outputs as master, inputs as slave.
// - GPIO zero becomes an output when used as the WLAN wake line.
// - Power-on pull-downs are on at reset and software can disable them.
module rhpm_pin_mux (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output reg [31:0] prdata_out,
  output wire pslverr_out,
  input wire host_link_clear_to_send_n_in,
  output reg host_link_request_to_send_n_in_unused_out,
  input wire host_link_serial_in_in,
  output reg host_link_serial_out_out,
  output reg host_link_rts_oe_n_out,
  output reg host_link_cts_out_out,
  output reg host_link_cts_oe_n_out,
  input wire device_wake_line_in,
  output reg device_wake_line_out,
  output reg device_wake_line_oe_n_out,
  input wire host_wake_line_in,
  output reg host_wake_line_out,
  output reg host_wake_line_oe_n_out,
  input wire core_link_tx_in,
  output reg core_link_tx_hold_out,
  output reg core_link_rx_out,
  input wire core_link_rx_ready_in,
  input wire core_host_wake_in,
  output reg core_dev_wake_out,
  output reg core_sleep_inband_out,
  input wire core_pcm_clk_in,
  input wire core_pcm_out_in,
  input wire core_pcm_sync_in,
  output reg core_pcm_in_out,
  input wire audio_bit_clock_in,
  output reg audio_bit_clock_out,
  output reg audio_bit_clock_oe_n_out,
  input wire audio_word_select_in,
  output reg audio_word_select_out,
  output reg audio_word_select_oe_n_out,
  input wire core_audio_clk_in,
  input wire core_audio_ws_in,
  output reg core_audio_clk_out,
  output reg core_audio_ws_out,
  input wire wlan_power_on_in,
  input wire radio_power_on_in,
  output reg wlan_pulldown_en_out,
  output reg radio_pulldown_en_out,
  output reg wlan_reset_n_out,
  output reg wlan_reg_en_out,
  output reg radio_reset_n_out,
  output reg radio_reg_en_out,
  input wire wlan_wake_out_in,
  input wire gpio0_pin_in,
  output reg gpio0_pin_out,
  output reg gpio0_oe_n_out,
  output reg gpio0_sample_out
);

  // ****************************************************************
  // Input synchronisers: three stages, change accepted when 2 and 3 agree
  // ****************************************************************
  localparam NSYNC = 8;
  // CTS is active low, so its stages idle high out of reset; a zero there
  // would let the core transmit before the host has granted anything.
  localparam [NSYNC-1:0] SYNC_RST = 8'h01;
  wire [NSYNC-1:0] raw_w;
  reg [NSYNC-1:0] s1_r;
  reg [NSYNC-1:0] s2_r;
  reg [NSYNC-1:0] s3_r;
  reg [NSYNC-1:0] clean_r;
  assign raw_w = {gpio0_pin_in, audio_word_select_in, audio_bit_clock_in,
                  radio_power_on_in, wlan_power_on_in, host_wake_line_in,
                  device_wake_line_in, host_link_clear_to_send_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk_in) begin
        if (!nrst_in) begin
          s1_r[gi] <= SYNC_RST[gi];
          s2_r[gi] <= SYNC_RST[gi];
          s3_r[gi] <= SYNC_RST[gi];
          clean_r[gi] <= SYNC_RST[gi];
        end else begin
          s1_r[gi] <= raw_w[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            clean_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  wire cts_n_w = clean_r[0];
  wire dev_wake_w = clean_r[1];
  wire host_wake_w = clean_r[2];
  wire wl_on_w = clean_r[3];
  wire rd_on_w = clean_r[4];
  wire abclk_w = clean_r[5];
  wire aws_w = clean_r[6];
  wire gpio0_w = clean_r[7];

  // ****************************************************************
  // APB register file
  // ****************************************************************
  reg route_pcm_r;
  reg audio_master_r;
  reg [4:0] gpio_r;
  reg [1:0] pd_r;

  // Reset words are full bus width; only the implemented low bits are kept
  wire [31:0] route_rst_w = `RHPM_ROUTE_RST;
  wire [31:0] audio_rst_w = `RHPM_AUDIO_RST;
  wire [31:0] gpio_rst_w = `RHPM_GPIO_RST;
  wire [31:0] pwr_rst_w = `RHPM_PWR_RST;

  function addr_hit;
    input [11:0] a;
    input [11:0] b;
    begin
      addr_hit = (a == b);
    end
  endfunction

  wire wr_w = psel_in & penable_in & pwrite_in;
  wire mapped_w = addr_hit(paddr_in, `RHPM_ADDR_ROUTE) |
                  addr_hit(paddr_in, `RHPM_ADDR_AUDIO) |
                  addr_hit(paddr_in, `RHPM_ADDR_GPIO) |
                  addr_hit(paddr_in, `RHPM_ADDR_PWR) |
                  addr_hit(paddr_in, `RHPM_ADDR_STATUS);
  // Zero wait states: every access ends in its first access cycle
  assign pready_out = 1'b1;
  // Unmapped offsets answer with an error and leave every register alone
  assign pslverr_out = psel_in & penable_in & ~mapped_w;

  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      route_pcm_r <= route_rst_w[0];
      audio_master_r <= audio_rst_w[0];
      gpio_r <= gpio_rst_w[4:0];
      pd_r <= pwr_rst_w[1:0];
    end else if (wr_w) begin
      if (addr_hit(paddr_in, `RHPM_ADDR_ROUTE)) begin
        route_pcm_r <= pwdata_in[`RHPM_ROUTE_PCM_BIT];
      end
      if (addr_hit(paddr_in, `RHPM_ADDR_AUDIO)) begin
        audio_master_r <= pwdata_in[`RHPM_AUDIO_MASTER_BIT];
      end
      if (addr_hit(paddr_in, `RHPM_ADDR_GPIO)) begin
        gpio_r <= pwdata_in[4:0];
      end
      if (addr_hit(paddr_in, `RHPM_ADDR_PWR)) begin
        pd_r <= pwdata_in[1:0];
      end
    end
  end

  always @* begin
    prdata_out = 32'h0000_0000;
    // Unimplemented bits and unmapped offsets read as zero
    case (paddr_in)
      `RHPM_ADDR_ROUTE: begin
        prdata_out[0] = route_pcm_r;
      end
      `RHPM_ADDR_AUDIO: begin
        prdata_out[0] = audio_master_r;
      end
      `RHPM_ADDR_GPIO: begin
        prdata_out[4:0] = gpio_r;
      end
      `RHPM_ADDR_PWR: begin
        prdata_out[1:0] = pd_r;
      end
      `RHPM_ADDR_STATUS: begin
        prdata_out[7:0] = clean_r;
      end
      default: begin
        prdata_out = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************************
  // Pin routing, registered so all enables move on one edge
  // ****************************************************************
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      host_link_request_to_send_n_in_unused_out <= 1'b1;
      host_link_rts_oe_n_out <= 1'b0;
      host_link_cts_out_out <= 1'b0;
      host_link_cts_oe_n_out <= 1'b1;
      host_link_serial_out_out <= 1'b1;
      core_link_tx_hold_out <= 1'b1;
      core_link_rx_out <= 1'b1;
      device_wake_line_out <= 1'b0;
      device_wake_line_oe_n_out <= 1'b1;
      host_wake_line_out <= 1'b0;
      host_wake_line_oe_n_out <= 1'b1;
      core_dev_wake_out <= 1'b0;
      core_sleep_inband_out <= 1'b0;
      core_pcm_in_out <= 1'b0;
    end else begin
      host_link_serial_out_out <= core_link_tx_in;
      core_link_rx_out <= host_link_serial_in_in;
      core_sleep_inband_out <= route_pcm_r;
      if (route_pcm_r) begin
        // PCM onto link and wake pins
        host_link_request_to_send_n_in_unused_out <= core_pcm_clk_in;
        host_link_rts_oe_n_out <= 1'b0;
        host_link_cts_out_out <= core_pcm_out_in;
        host_link_cts_oe_n_out <= 1'b0;
        host_wake_line_out <= core_pcm_sync_in;
        host_wake_line_oe_n_out <= 1'b0;
        device_wake_line_out <= 1'b0;
        device_wake_line_oe_n_out <= 1'b1;
        core_pcm_in_out <= dev_wake_w;
        core_dev_wake_out <= 1'b0;
        core_link_tx_hold_out <= 1'b0;
      end else begin
        host_link_request_to_send_n_in_unused_out <= ~core_link_rx_ready_in;
        host_link_rts_oe_n_out <= 1'b0;
        host_link_cts_out_out <= 1'b0;
        host_link_cts_oe_n_out <= 1'b1;
        core_link_tx_hold_out <= cts_n_w;
        host_wake_line_out <= gpio_r[`RHPM_WAKE_OE_BIT] ?
                              gpio_r[`RHPM_WAKE_DO_BIT] : core_host_wake_in;
        host_wake_line_oe_n_out <= 1'b0;
        device_wake_line_out <= 1'b0;
        device_wake_line_oe_n_out <= 1'b1;
        core_dev_wake_out <= dev_wake_w;
        core_pcm_in_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Audio direction
  // ****************************************************************
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      audio_bit_clock_out <= 1'b0;
      audio_bit_clock_oe_n_out <= 1'b1;
      audio_word_select_out <= 1'b0;
      audio_word_select_oe_n_out <= 1'b1;
      core_audio_clk_out <= 1'b0;
      core_audio_ws_out <= 1'b0;
    end else begin
      audio_bit_clock_out <= core_audio_clk_in;
      audio_word_select_out <= core_audio_ws_in;
      audio_bit_clock_oe_n_out <= ~audio_master_r;
      audio_word_select_oe_n_out <= ~audio_master_r;
      core_audio_clk_out <= audio_master_r ? core_audio_clk_in : abclk_w;
      core_audio_ws_out <= audio_master_r ? core_audio_ws_in : aws_w;
    end
  end

  // ****************************************************************
  // Power sections
  // ****************************************************************
  // Sections stay in reset until the filtered power-on level is high, so a
  // one-cycle glitch on a floating input never releases them
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      wlan_pulldown_en_out <= 1'b1;
      radio_pulldown_en_out <= 1'b1;
      wlan_reset_n_out <= 1'b0;
      wlan_reg_en_out <= 1'b0;
      radio_reset_n_out <= 1'b0;
      radio_reg_en_out <= 1'b0;
    end else begin
      wlan_pulldown_en_out <= pd_r[`RHPM_PWR_WL_PD_BIT];
      radio_pulldown_en_out <= pd_r[`RHPM_PWR_RD_PD_BIT];
      wlan_reset_n_out <= wl_on_w;
      wlan_reg_en_out <= wl_on_w;
      radio_reset_n_out <= rd_on_w;
      radio_reg_en_out <= rd_on_w;
    end
  end

  // ****************************************************************
  // GPIO zero
  // ****************************************************************
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      gpio0_pin_out <= 1'b0;
      gpio0_oe_n_out <= 1'b1;
      gpio0_sample_out <= 1'b0;
    end else begin
      if (gpio_r[`RHPM_GPIO0_WAKE_BIT]) begin
        gpio0_pin_out <= wlan_wake_out_in;
        gpio0_oe_n_out <= 1'b0;
      end else begin
        gpio0_pin_out <= gpio_r[`RHPM_GPIO0_DO_BIT];
        gpio0_oe_n_out <= ~gpio_r[`RHPM_GPIO0_OE_BIT];
      end
      gpio0_sample_out <= gpio0_w;
    end
  end

endmodule

// >>> test/rhpm_host_model.sv
// Host processor model: flow control, serial data, wake and power-on.
// Assumes the bench resolves every shared pin.
`timescale 1ns/1ps
module rhpm_host_model (
  input wire clk_in,
  input wire allow_in,
  input wire rts_n_in,
  input wire data_in,
  input wire wake_in,
  input wire [1:0] pwr_in,
  output reg cts_n_out = 1'h1,
  output reg serial_out = 1'h1,
  output reg wake_out = 1'h0,
  output reg [1:0] pwr_out = 2'h0,
  output reg tick_out = 1'h0
);
// ****
// Host side
// ****
always @(posedge clk_in) begin
  tick_out <= ~tick_out;
  cts_n_out <= ~allow_in;
  serial_out <= rts_n_in ? 1'h1 : data_in;
  wake_out <= wake_in;
  pwr_out <= pwr_in;
end
endmodule

// >>> test/rhpm_mux_assertions.sv
// Port checker for the radio host pin mux.
// Assumes a bind onto rhpm_pin_mux with ports joined by name.
`timescale 1ns/1ps
module rhpm_mux_assertions (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire core_link_tx_in,
  input wire host_link_serial_out_out,
  input wire host_link_rts_oe_n_out,
  input wire host_link_request_to_send_n_in_unused_out,
  input wire core_link_rx_ready_in,
  input wire core_pcm_clk_in,
  input wire core_sleep_inband_out,
  input wire host_link_cts_oe_n_out,
  input wire core_link_tx_hold_out,
  input wire wlan_reset_n_out,
  input wire wlan_reg_en_out,
  input wire wlan_pulldown_en_out
);
// ****
// Checks
// ****
wire rts = host_link_request_to_send_n_in_unused_out;
wire pcm = core_sleep_inband_out;
default clocking @(posedge sys_clk_in); endclocking
default disable iff (!nrst_in);
chk_rts_driven: assert property (!host_link_rts_oe_n_out)
  else $error("rts pin not driven");
chk_tx_path: assert property ($past(nrst_in) |->
  host_link_serial_out_out == $past(core_link_tx_in)) else $error("tx path");
chk_cts_swap: assert property (host_link_cts_oe_n_out == !pcm)
  else $error("cts enable out of step with route");
chk_no_hold: assert property (pcm |-> !core_link_tx_hold_out)
  else $error("hold asserted in pcm route");
chk_pcm_clock: assert property (pcm && $past(pcm) |->
  rts == $past(core_pcm_clk_in)) else $error("pcm clock not on rts");
chk_rts_ready: assert property ($past(nrst_in) && !pcm && !$past(pcm)
  |-> rts == !$past(core_link_rx_ready_in)) else $error("rts level");
chk_wlan_pair: assert property (wlan_reset_n_out == wlan_reg_en_out)
  else $error("wlan reset and regulator differ");
chk_pd_reset: assert property ($rose(nrst_in) |-> wlan_pulldown_en_out)
  else $error("pulldown off at reset");
endmodule

// >>> test/tb_radio_host_pin_mux.sv
// Bench for the radio host pin mux with a host model on the link.
// Assumes rtl/ on the include path.
`timescale 1ns/1ps
`include "rhpm_defs.vh"
`define C(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_radio_host_pin_mux;
// ****
// Bench
// ****
reg sys_clk_in = 1'h0, nrst_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
reg pwrite_in = 1'h0, core_link_tx_in = 1'h1, core_link_rx_ready_in = 1'h0;
reg core_host_wake_in = 1'h0, core_pcm_clk_in = 1'h0, core_pcm_out_in = 1'h0;
reg core_pcm_sync_in = 1'h0, core_audio_clk_in = 1'h0, core_audio_ws_in = 1'h0;
reg wlan_wake_out_in = 1'h0, allow = 1'h0, hdata = 1'h1, hwake = 1'h0, er;
reg [1:0] pwr = 2'h0;
reg [11:0] paddr_in = 12'h000;
reg [31:0] pwdata_in = 32'h0000_0000, rd;
integer num_errors = 0, num_checks = 0, cyc = 0;
wire pready_out, pslverr_out, host_link_request_to_send_n_in_unused_out;
wire [31:0] prdata_out;
wire host_link_serial_out_out, host_link_rts_oe_n_out, host_link_cts_out_out;
wire host_link_cts_oe_n_out, device_wake_line_out, device_wake_line_oe_n_out;
wire host_wake_line_out, host_wake_line_oe_n_out, core_link_tx_hold_out;
wire core_link_rx_out, core_dev_wake_out, core_sleep_inband_out;
wire core_pcm_in_out, audio_bit_clock_out, audio_bit_clock_oe_n_out;
wire audio_word_select_out, audio_word_select_oe_n_out, core_audio_clk_out;
wire core_audio_ws_out, wlan_pulldown_en_out, radio_pulldown_en_out;
wire wlan_reset_n_out, wlan_reg_en_out, radio_reset_n_out, radio_reg_en_out;
wire gpio0_pin_out, gpio0_oe_n_out, gpio0_sample_out, hcts, hdw, tick;
wire host_link_serial_in_in, wlan_power_on_in, radio_power_on_in;
wire host_link_clear_to_send_n_in = host_link_cts_oe_n_out ? hcts :
  host_link_cts_out_out;
wire device_wake_line_in = device_wake_line_oe_n_out ? hdw :
  device_wake_line_out;
wire host_wake_line_in = host_wake_line_oe_n_out ? tick : host_wake_line_out;
wire audio_bit_clock_in = audio_bit_clock_oe_n_out ? tick :
  audio_bit_clock_out;
wire audio_word_select_in = audio_word_select_oe_n_out ? ~tick :
  audio_word_select_out;
wire gpio0_pin_in = gpio0_oe_n_out ? tick : gpio0_pin_out;
rhpm_host_model u_host (.clk_in(sys_clk_in), .allow_in(allow),
  .rts_n_in(host_link_request_to_send_n_in_unused_out), .data_in(hdata),
  .wake_in(hwake), .pwr_in(pwr), .cts_n_out(hcts),
  .serial_out(host_link_serial_in_in), .wake_out(hdw), .tick_out(tick),
  .pwr_out({radio_power_on_in, wlan_power_on_in}));
rhpm_pin_mux u_dut (.*);
initial forever #10 sys_clk_in = ~sys_clk_in;
task close_out;
  if (num_errors == 0 && num_checks > 0)
    $display("NO MISMATCHES");
  else
    $display("MISMATCHES SEEN");
  $finish;
endtask
always @(posedge sys_clk_in) begin
  cyc = cyc + 1;
  if (cyc == 3000) begin
    num_errors = num_errors + 1;
    close_out;
  end
end
task apb(input w, input [11:0] a, input [31:0] d);
  @(posedge sys_clk_in);
  psel_in <= 1'h1;
  pwrite_in <= w;
  paddr_in <= a;
  pwdata_in <= d;
  @(posedge sys_clk_in);
  penable_in <= 1'h1;
  @(posedge sys_clk_in);
  while (pready_out !== 1'h1) @(posedge sys_clk_in);
  rd = prdata_out;
  er = pslverr_out;
  psel_in <= 1'h0;
  penable_in <= 1'h0;
endtask
task tk(input integer n);
  repeat (n) @(posedge sys_clk_in);
  #1;
endtask
task t_reset;
  tk(1);
  `C({host_link_rts_oe_n_out, host_link_cts_oe_n_out}, 2'h1)
  `C({host_wake_line_oe_n_out, device_wake_line_oe_n_out}, 2'h1)
  `C({wlan_reset_n_out, radio_reg_en_out}, 2'h0)
  apb(1'h0, `RHPM_ADDR_PWR, 32'h0000_0000);
  `C(rd, 32'h0000_0003)
endtask
task t_link;
  @(posedge sys_clk_in);
  core_link_tx_in <= 1'h0;
  core_link_rx_ready_in <= 1'h1;
  hdata <= 1'h0;
  tk(3);
  `C(host_link_serial_out_out, 1'h0)
  `C(host_link_request_to_send_n_in_unused_out, 1'h0)
  `C({core_link_rx_out, core_link_tx_hold_out}, 2'h1)
  @(posedge sys_clk_in);
  allow <= 1'h1;
  tk(8);
  `C(core_link_tx_hold_out, 1'h0)
endtask
task t_pcm;
  @(posedge sys_clk_in);
  core_pcm_out_in <= 1'h1;
  core_host_wake_in <= 1'h1;
  hwake <= 1'h1;
  apb(1'h1, `RHPM_ADDR_ROUTE, 32'h0000_0001);
  tk(8);
  `C({core_sleep_inband_out, core_link_tx_hold_out}, 2'h2)
  `C({host_link_cts_oe_n_out, host_link_cts_out_out}, 2'h1)
  `C({host_wake_line_oe_n_out, host_wake_line_out}, 2'h0)
  `C(core_pcm_in_out, 1'h1)
  apb(1'h1, `RHPM_ADDR_ROUTE, 32'h0000_0000);
  tk(2);
  `C({host_link_cts_oe_n_out, host_wake_line_out, core_sleep_inband_out}, 3'h6)
  `C(core_dev_wake_out, 1'h1)
endtask
task t_audio;
  @(posedge sys_clk_in);
  core_audio_clk_in <= 1'h1;
  apb(1'h1, `RHPM_ADDR_AUDIO, 32'h0000_0001);
  tk(2);
  `C({audio_bit_clock_oe_n_out, audio_word_select_oe_n_out}, 2'h0)
  `C({audio_bit_clock_out, core_audio_clk_out}, 2'h3)
  apb(1'h1, `RHPM_ADDR_AUDIO, 32'h0000_0000);
  tk(2);
  `C({audio_bit_clock_oe_n_out, audio_word_select_oe_n_out}, 2'h3)
endtask
task t_power;
  @(posedge sys_clk_in);
  pwr <= 2'h1;
  tk(8);
  `C({wlan_reset_n_out, wlan_reg_en_out}, 2'h3)
  `C({radio_reset_n_out, radio_reg_en_out}, 2'h0)
  @(posedge sys_clk_in);
  pwr <= 2'h3;
  tk(8);
  `C({radio_reset_n_out, radio_reg_en_out}, 2'h3)
  apb(1'h1, `RHPM_ADDR_PWR, 32'h0000_0000);
  tk(2);
  `C({wlan_pulldown_en_out, radio_pulldown_en_out}, 2'h0)
  apb(1'h0, 12'h014, 32'h0000_0000);
  `C({er, rd}, {1'h1, 32'h0000_0000})
endtask
task t_gpio;
  @(posedge sys_clk_in);
  wlan_wake_out_in <= 1'h1;
  apb(1'h1, `RHPM_ADDR_GPIO, 32'h0000_0001);
  tk(2);
  `C({gpio0_oe_n_out, gpio0_pin_out}, 2'h1)
  tk(8);
  `C(gpio0_sample_out, 1'h1)
endtask
initial begin
  repeat (12) @(posedge sys_clk_in);
  nrst_in <= 1'h1;
  t_reset;
  t_link;
  t_pcm;
  t_audio;
  t_power;
  t_gpio;
  close_out;
end
endmodule
bind rhpm_pin_mux rhpm_mux_assertions u_chk (.*);
